// ### rtl/strobe_decode.sv
// Decodes either strobe style of the processor port into start and finish pulses.
// Assumes the port pins are synchronous to clk.
`timescale 1ns/1ps
module strobe_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic shared_mode,
  input wire tone_pkg::sel_t sel,
  input wire logic ale,
  input wire logic rw,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic enable_n,
  output logic start,
  output logic finish,
  output logic is_read,
  output tone_pkg::sel_t sel_q,
  output tone_pkg::sel_t sel_now
);
  import tone_pkg::*;
  strobe_state_t s_q, s_d;
  logic act_now;
  logic read_now;

  // =====================================================================
  // Decode
  // Shared style selects with the latch line and direction line.
  always_comb begin
    act_now = shared_mode ? ~enable_n : (~rd_n | ~wr_n);
    read_now = shared_mode ? rw : ~rd_n;
    sel_now = shared_mode ? {ale, rw} : sel;
    start = act_now & ~s_q.active;
    finish = ~act_now & s_q.active;
    s_d = s_q;
    s_d.active = act_now;
    if (start) begin
      s_d.read = read_now;
      s_d.sel = sel_now;
    end
  end

  assign is_read = s_q.read;
  assign sel_q = s_q.sel;

  // State register, frozen while ce is low.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule

// ### rtl/tone_bus_if.sv
// Pins of the 4-bit processor port between the host and the transceiver.
// Assumes both ends run on one clock; the shared data wire is resolved here.
`timescale 1ns/1ps
`include "tone_map.svh"
interface tone_bus_if;
  import tone_pkg::*;
  // =====================================================================
  // Pins
  logic power_down_pin;
  logic shared_mode;
  sel_t sel;
  logic ale;
  logic rw;
  logic rd_n;
  logic wr_n;
  logic enable_n;
  nib_t host_data;
  logic host_data_oe;
  nib_t dev_data;
  logic dev_data_oe;
  nib_t data;

  // Wire level from the enables; an undriven wire reads as zero.
  always_comb begin
    if (host_data_oe) begin
      data = host_data;
    end else if (dev_data_oe) begin
      data = dev_data;
    end else begin
      data = `NIB_ZERO;
    end
  end

  modport device (input power_down_pin, input shared_mode, input sel, input ale, input rw,
                  input rd_n, input wr_n, input enable_n, input data,
                  output dev_data, output dev_data_oe);
  modport host (output power_down_pin, output shared_mode, output sel, output ale, output rw,
                output rd_n, output wr_n, output enable_n, output host_data,
                output host_data_oe, input data);
endinterface

// ### rtl/tone_device.sv
// Register bank and detector status logic of the tone transceiver, device end of the port.
// Assumes raw detector levels arrive synchronous to clk from the analog front end.
// How it works
// - Power-down pin high holds everything reset.
// - Host holds power-down 200 us first.
// - Select 00 writes transmit digit code.
// - Select 01 reads received digit code.
// - Control bit D0 starts digit tone.
// - Host ends digit with zero control write.
// - Control bit D2 selects fast detection.
// - Status select 11; reading clears event.
// - Signal-absent bit reads one when idle.
// - D1 enables progress detect; status 1011.
// - D3 starts progress tone; zero stops.
// - All four functions run concurrently.
// - Control bits D3 D2 D1 D0 meanings.
// - Event sets on detect edges; read clears.
// - Digit change while sending keeps frequencies.
`timescale 1ns/1ps
`include "tone_map.svh"
module tone_device (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  tone_bus_if.device bus,
  input wire logic digit_present,
  input wire tone_pkg::nib_t rx_digit,
  input wire logic progress_in,
  input wire logic fax_in,
  output logic tone_out_enable,
  output tone_pkg::nib_t tone_digit,
  output logic progress_tone_out_enable,
  output logic fast_detect_select,
  output logic progress_detect_enable,
  output logic progress_tone_present,
  output logic fax_tone_present,
  output logic signal_absent,
  output logic detect_event_flag
);
  import tone_pkg::*;

  // =====================================================================
  // Scope
  // Only the digital side lives here: the generators and detectors sit outside
  // and see nothing but the enables and codes that this bank registers.
  // Detector levels are taken once per clock with no filtering, so any debounce
  // belongs to the front end that drives them.

  // =====================================================================
  // Declarations
  dev_state_t s_q, s_d;
  logic rst;
  logic start;
  logic finish;
  logic is_read;
  sel_t sel_q;
  sel_t sel_now;
  logic sig_absent_now;
  logic prog_now;
  logic fax_now;
  logic event_set;
  logic event_clr;
  logic status_read_done;
  logic write_done;
  logic digit_arrive;
  logic read_strobe_low;

  // Register read multiplexer, shared by every read start.
  function automatic nib_t read_mux(input sel_t sel, input dev_state_t s);
    nib_t r;
    r = `NIB_ZERO;
    unique case (sel)
      `SEL_RX_DIGIT: r = s.rx_digit;
      `SEL_STATUS: r = {s.sig_absent, s.fax, s.prog, s.event_flag};
      `SEL_TX_DIGIT: r = `NIB_ZERO;
      `SEL_CONTROL: r = `NIB_ZERO;
    endcase
    return r;
  endfunction

  // Rising edge of a level against its registered copy; every detector event is one.
  function automatic logic level_rise(input logic was, input logic cur);
    return ~was & cur;
  endfunction

  // =====================================================================
  // Reset
  // The power-down pin acts as a synchronous reset over the whole bank.
  // A pulse on it shorter than one clock may be missed, which the long hold
  // that the host keeps at start-up makes harmless.
  assign rst = reset | bus.power_down_pin;

  // =====================================================================
  // Port strobe decoding
  strobe_decode u_decode (
    .clk(clk),
    .reset(rst),
    .ce(ce),
    .shared_mode(bus.shared_mode),
    .sel(bus.sel),
    .ale(bus.ale),
    .rw(bus.rw),
    .rd_n(bus.rd_n),
    .wr_n(bus.wr_n),
    .enable_n(bus.enable_n),
    .start(start),
    .finish(finish),
    .is_read(is_read),
    .sel_q(sel_q),
    .sel_now(sel_now)
  );

  // =====================================================================
  // Detector conditioning
  // Fax presence yields to progress tone, and both are held low unless enabled.
  // With D1 clear both presence bits read zero whatever the inputs do.
  always_comb begin
    sig_absent_now = ~digit_present;
    prog_now = s_q.ctrl[`CTRL_PROG_DET] & progress_in;
    fax_now = s_q.ctrl[`CTRL_PROG_DET] & fax_in & ~progress_in;
  end

  // =====================================================================
  // Event flag causes
  // A clear that meets a new detect edge loses, so no event is dropped.
  always_comb begin
    digit_arrive = level_rise(~s_q.sig_absent, ~sig_absent_now);
    event_set = digit_arrive
              | level_rise(s_q.fax, fax_now)
              | level_rise(s_q.prog, prog_now);
    status_read_done = finish & is_read & (sel_q == `SEL_STATUS);
    write_done = finish & ~is_read;
    // The flag also falls when every detected signal has gone away unread.
    event_clr = status_read_done | (sig_absent_now & ~fax_now & ~prog_now);
  end

  // =====================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Detectors update every cycle, independent of the generators.
    s_d.sig_absent = sig_absent_now;
    s_d.fax = fax_now;
    s_d.prog = prog_now;
    if (event_set) begin
      s_d.event_flag = 1'b1;
    end else if (event_clr) begin
      s_d.event_flag = 1'b0;
    end
    // The received code is caught as the digit is recognised.
    if (digit_arrive) begin
      s_d.rx_digit = rx_digit;
    end
    // Read data is frozen at strobe start so a clear cannot tear it.
    if (start) begin
      s_d.rdata = read_mux(sel_now, s_q);
    end
    // Writes commit as the strobe ends, when the host data is settled.
    // Writes to the read-only selects leave every register as it was.
    if (write_done) begin
      unique case (sel_q)
        `SEL_TX_DIGIT: s_d.tx_digit = bus.data;
        `SEL_CONTROL: s_d.ctrl = bus.data;
        `SEL_RX_DIGIT: s_d.tx_digit = s_q.tx_digit;
        `SEL_STATUS: s_d.tx_digit = s_q.tx_digit;
      endcase
    end
    // The generator code follows the loaded digit only while tone is off,
    // so a reload during a tone reaches the generator code once the tone is turned off.
    if (~s_q.ctrl[`CTRL_TONE_OUT]) begin
      s_d.gen_digit = s_d.tx_digit;
    end
  end

  // =====================================================================
  // State register
  // Idle status reads 1000 after reset: signal absent, nothing else.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.sig_absent <= `SIG_ABSENT_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Port data drive
  // A read strobe is low in whichever style the strap selects.
  assign read_strobe_low = bus.shared_mode ? ~bus.enable_n : ~bus.rd_n;
  // Drive only during a read strobe after its start cycle has loaded data.
  // Start and finish cycles stay undriven, so the host never sees the last
  // access's data and the wire turns round before the host drives again.
  assign bus.dev_data = s_q.rdata;
  assign bus.dev_data_oe = is_read & ~start & ~finish & ~rst & read_strobe_low;

  // =====================================================================
  // User side outputs
  // Each generator has its own control bit; D1 enables both progress and fax detect, and progress presence masks fax.
  assign tone_out_enable = s_q.ctrl[`CTRL_TONE_OUT];
  assign tone_digit = s_q.gen_digit;
  assign progress_tone_out_enable = s_q.ctrl[`CTRL_PROG_OUT];
  assign fast_detect_select = s_q.ctrl[`CTRL_FAST_DET];
  assign progress_detect_enable = s_q.ctrl[`CTRL_PROG_DET];
  assign progress_tone_present = s_q.prog;
  assign fax_tone_present = s_q.fax;
  assign signal_absent = s_q.sig_absent;
  assign detect_event_flag = s_q.event_flag;
endmodule

// ### rtl/tone_host.sv
// Host end of the processor port: power-down sequence and single register accesses.
// Assumes the user issues one command at a time and paces on/off times itself.
`timescale 1ns/1ps
`include "tone_map.svh"
module tone_host #(
  parameter logic [15:0] PD_HOLD_CYCLES = 16'((`PD_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  tone_bus_if.host bus,
  input wire logic shared_select,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire tone_pkg::sel_t cmd_reg,
  input wire tone_pkg::nib_t cmd_wdata,
  output logic rsp_valid,
  output tone_pkg::nib_t rsp_data,
  output logic init_done
);
  import tone_pkg::*;
  host_state_t s_q, s_d;

  // =====================================================================
  // Sequencer
  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    unique case (s_q.st)
      H_PD_HOLD: begin
        // Strobe style is caught while the device is still held in reset.
        s_d.shared = shared_select;
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == PD_HOLD_CYCLES - 16'h0001) begin
          s_d.st = H_IDLE;
          s_d.cnt = '0;
        end
      end
      H_IDLE: begin
        // Commands forward as given; off and on times are the user's pacing.
        if (cmd_valid) begin
          s_d.st = H_SETUP;
          s_d.write = cmd_write;
          s_d.sel = cmd_reg;
          s_d.wdata = cmd_wdata;
        end
      end
      H_SETUP: begin
        s_d.st = H_STROBE;
        s_d.cnt = '0;
      end
      H_STROBE: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == `STROBE_CYCLES - 16'h0001) begin
          s_d.st = H_RELEASE;
          s_d.rdata = bus.data;
        end
      end
      H_RELEASE: begin
        s_d.st = H_IDLE;
        s_d.rsp = 1'b1;
      end
    endcase
  end

  // State register, frozen while ce is low.
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= H_PD_HOLD;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Pins
  // Shared style encodes the register as latch line and direction line.
  assign bus.power_down_pin = (s_q.st == H_PD_HOLD);
  assign bus.shared_mode = s_q.shared;
  assign bus.sel = s_q.sel;
  assign bus.ale = s_q.sel[1];
  assign bus.rw = ~s_q.write;
  assign bus.enable_n = ~(s_q.shared & (s_q.st == H_STROBE));
  assign bus.rd_n = ~(~s_q.shared & ~s_q.write & (s_q.st == H_STROBE));
  assign bus.wr_n = ~(~s_q.shared & s_q.write & (s_q.st == H_STROBE));
  assign bus.host_data = s_q.wdata;
  assign bus.host_data_oe = s_q.write & (s_q.st != H_PD_HOLD) & (s_q.st != H_IDLE);

  // =====================================================================
  // User side
  assign cmd_ready = (s_q.st == H_IDLE);
  assign rsp_valid = s_q.rsp;
  assign rsp_data = s_q.rdata;
  assign init_done = (s_q.st != H_PD_HOLD);
endmodule

// ### rtl/tone_map.svh
// Register selects, bit positions, reset values and timing of the tone transceiver port.
// Assumes inclusion from the package and from design files that decode the port.
`ifndef TONE_MAP_SVH
`define TONE_MAP_SVH
// =====================================================================
// Register selects
`define SEL_TX_DIGIT 2'h0
`define SEL_RX_DIGIT 2'h1
`define SEL_CONTROL 2'h2
`define SEL_STATUS 2'h3
// =====================================================================
// Control bit positions
`define CTRL_PROG_OUT 3
`define CTRL_FAST_DET 2
`define CTRL_PROG_DET 1
`define CTRL_TONE_OUT 0
// =====================================================================
// Status bit positions and reset values
`define STAT_SIG_ABSENT 3
`define STAT_FAX 2
`define STAT_PROG 1
`define STAT_EVENT 0
`define NIB_ZERO 4'h0
`define SIG_ABSENT_RESET 1'b1
// =====================================================================
// Host timing
`define PD_HOLD_NS 200000
`define CLK_PERIOD_NS 8
`define STROBE_CYCLES 16'h0004
`endif

// ### rtl/tone_pkg.sv
// Types shared by both ends of the tone transceiver processor port.
// Assumes the map header is on the include path.
`include "tone_map.svh"
package tone_pkg;
  // =====================================================================
  // Common types
  typedef logic [3:0] nib_t;
  typedef logic [1:0] sel_t;

  // Strobe decoder state.
  typedef struct packed {
    logic active;
    logic read;
    sel_t sel;
  } strobe_state_t;

  // Device end state.
  typedef struct packed {
    nib_t ctrl;
    nib_t tx_digit;
    nib_t gen_digit;
    nib_t rx_digit;
    nib_t rdata;
    logic sig_absent;
    logic fax;
    logic prog;
    logic event_flag;
  } dev_state_t;

  // Host sequencer states.
  typedef enum logic [2:0] {H_PD_HOLD, H_IDLE, H_SETUP, H_STROBE, H_RELEASE} host_st_t;

  // Host end state.
  typedef struct packed {
    host_st_t st;
    logic [15:0] cnt;
    logic shared;
    logic write;
    sel_t sel;
    nib_t wdata;
    nib_t rdata;
    logic rsp;
  } host_state_t;
endpackage

// ### test/tb_top.sv
// Testbench joining host and device ends of the tone port through the interface.
// Assumes the design package, header and interface are compiled first.
`timescale 1ns/1ps
`include "tone_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  import tone_pkg::*;
  logic clk, reset, shared_select, cmd_valid, cmd_write, cmd_ready, rsp_valid, init_done;
  sel_t cmd_reg;
  nib_t cmd_wdata, rsp_data, rx_digit, tone_digit;
  logic digit_present, progress_in, fax_in, tone_out_enable, progress_tone_out_enable;
  logic fast_detect_select, progress_detect_enable, progress_tone_present, fax_tone_present;
  logic signal_absent, detect_event_flag;
  int n_mismatch = 0;
  int check_count = 0;

  // =====================================================================
  // Structure
  tone_bus_if tone_bus_if_i ();
  tone_host #(.PD_HOLD_CYCLES(16'h0008)) tone_host_i (.clk(clk), .reset(reset), .ce(1'b1),
    .bus(tone_bus_if_i.host), .shared_select(shared_select), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .init_done(init_done));
  tone_device tone_device_i (.clk(clk), .reset(reset), .ce(1'b1), .bus(tone_bus_if_i.device),
    .digit_present(digit_present), .rx_digit(rx_digit), .progress_in(progress_in), .fax_in(fax_in),
    .tone_out_enable(tone_out_enable), .tone_digit(tone_digit),
    .progress_tone_out_enable(progress_tone_out_enable), .fast_detect_select(fast_detect_select),
    .progress_detect_enable(progress_detect_enable), .progress_tone_present(progress_tone_present),
    .fax_tone_present(fax_tone_present), .signal_absent(signal_absent),
    .detect_event_flag(detect_event_flag));
  tone_properties tone_properties_i (.clk(clk), .reset(reset), .power_down_pin(tone_bus_if_i.power_down_pin),
    .shared_mode(tone_bus_if_i.shared_mode), .sel(tone_bus_if_i.sel), .rw(tone_bus_if_i.rw),
    .rd_n(tone_bus_if_i.rd_n), .wr_n(tone_bus_if_i.wr_n), .enable_n(tone_bus_if_i.enable_n),
    .host_data_oe(tone_bus_if_i.host_data_oe), .dev_data_oe(tone_bus_if_i.dev_data_oe));

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // =====================================================================
  // Tasks
  // One host command; the next may start from the response cycle, so no idle gap is added.
  task automatic xfer(input logic w, input sel_t r, input nib_t d, output nib_t q);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_reg <= r;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    q = rsp_data;
  endtask

  task automatic wr(input sel_t r, input nib_t d);
    nib_t q;
    xfer(1'b1, r, d, q);
  endtask

  task automatic rd(input sel_t r, input nib_t e, input string nm);
    nib_t q;
    xfer(1'b0, r, 4'h0, q);
    `CHK(nm, e, q)
  endtask

  // Detector levels change on an edge; three cycles let the status registers settle.
  task automatic stim(input logic dp, input logic pr, input logic fx, input nib_t code);
    @(posedge clk);
    digit_present <= dp;
    progress_in <= pr;
    fax_in <= fx;
    rx_digit <= code;
    repeat (3) @(negedge clk);
  endtask

  // Full pass in one strobe style; the style strap is only read during power-down hold.
  task automatic run(input logic m);
    int i;
    @(posedge clk);
    reset <= 1'b1;
    shared_select <= m;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK("pd_pin", 1'b1, tone_bus_if_i.power_down_pin)
    `CHK("absent", 1'b1, signal_absent)
    `CHK("tone_on", 1'b0, tone_out_enable)
    `CHK("fast", 1'b0, fast_detect_select)
    for (i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge clk);
    `CHK("pd_pin", 1'b0, tone_bus_if_i.power_down_pin)
    `CHK("cmd_ready", 1'b1, cmd_ready)
    rd(`SEL_STATUS, 4'h8, "stat_idle");
    wr(`SEL_TX_DIGIT, 4'h5);
    wr(`SEL_CONTROL, 4'h1);
    `CHK("tone_on", 1'b1, tone_out_enable)
    `CHK("tone_digit", 4'h5, tone_digit)
    wr(`SEL_TX_DIGIT, 4'h9);
    `CHK("tone_digit", 4'h5, tone_digit)
    rd(`SEL_TX_DIGIT, 4'h0, "tx_readback");
    wr(`SEL_CONTROL, 4'h0);
    `CHK("tone_on", 1'b0, tone_out_enable)
    wr(`SEL_CONTROL, 4'h4);
    `CHK("tone_digit", 4'h9, tone_digit)
    `CHK("fast", 1'b1, fast_detect_select)
    `CHK("prog_det", 1'b0, progress_detect_enable)
    stim(1'b1, 1'b1, 1'b0, m ? 4'hC : 4'h7);
    rd(`SEL_STATUS, 4'h1, "stat_digit");
    rd(`SEL_STATUS, 4'h0, "stat_cleared");
    wr(`SEL_RX_DIGIT, 4'hF);
    rd(`SEL_RX_DIGIT, m ? 4'hC : 4'h7, "rx_code");
    stim(1'b0, 1'b0, 1'b0, 4'h0);
    rd(`SEL_STATUS, 4'h8, "stat_gone");
    wr(`SEL_CONTROL, 4'h2);
    stim(1'b0, 1'b1, 1'b0, 4'h0);
    `CHK("prog_present", 1'b1, progress_tone_present)
    `CHK("event_flag", 1'b1, detect_event_flag)
    rd(`SEL_STATUS, 4'hB, "stat_prog");
    rd(`SEL_STATUS, 4'hA, "stat_prog_rd");
    `CHK("event_flag", 1'b0, detect_event_flag)
    stim(1'b0, 1'b0, 1'b1, 4'h0);
    `CHK("fax_present", 1'b1, fax_tone_present)
    rd(`SEL_STATUS, 4'hD, "stat_fax");
    wr(`SEL_CONTROL, 4'hB);
    stim(1'b1, 1'b1, 1'b0, 4'h3);
    rd(`SEL_STATUS, 4'h3, "stat_conc");
    `CHK("tone_on", 1'b1, tone_out_enable)
    `CHK("prog_out", 1'b1, progress_tone_out_enable)
    wr(`SEL_CONTROL, 4'h0);
    `CHK("prog_out", 1'b0, progress_tone_out_enable)
    stim(1'b0, 1'b0, 1'b0, 4'h0);
    // Leave a control bit set so the next pass proves that reset clears it.
    wr(`SEL_CONTROL, 4'h4);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // =====================================================================
  // Main sequence: separate strobes first, then the shared style.
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    shared_select = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_reg = `SEL_TX_DIGIT;
    cmd_wdata = 4'h0;
    digit_present = 1'b0;
    rx_digit = 4'h0;
    progress_in = 1'b0;
    fax_in = 1'b0;
    run(1'b0);
    run(1'b1);
    finish_test();
  end

  // Watchdog; both passes need well under a thousand cycles, so this only trips on a hang.
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule

// ### test/tone_properties.sv
// Concurrent properties of the tone port, watching the interface wires.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/1ps
module tone_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_down_pin,
  input wire logic shared_mode,
  input wire tone_pkg::sel_t sel,
  input wire logic rw,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic enable_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  // =====================================================================
  // Helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic rd_strobe;
  logic wr_strobe;
  // Strobes of either style; the shared style reads while rw is high.
  assign rd_strobe = shared_mode ? (!enable_n && rw) : !rd_n;
  assign wr_strobe = shared_mode ? (!enable_n && !rw) : !wr_n;

  // =====================================================================
  // Assertions
  AST_PD_QUIET: assert property (power_down_pin |-> rd_n && wr_n && enable_n)
    else $error("strobe active during power-down hold");
  AST_PD_NO_DRIVE: assert property (power_down_pin |-> !dev_data_oe)
    else $error("device drives data while held in power-down");
  AST_READ_ONLY_DRIVE: assert property (dev_data_oe |-> rd_strobe && !host_data_oe)
    else $error("device drives data outside a read strobe");
  AST_READ_ANSWER: assert property ($rose(rd_strobe) |-> !dev_data_oe ##1 dev_data_oe [*3] ##1 !dev_data_oe)
    else $error("read data drive window is wrong");
  AST_WRITE_DRIVE: assert property (wr_strobe |-> host_data_oe)
    else $error("host not driving data during a write strobe");
  AST_WR_LEN: assert property ($fell(wr_n) |-> !wr_n [*4] ##1 wr_n)
    else $error("separate write strobe length is not four cycles");
  AST_SH_LEN: assert property ($fell(enable_n) |-> (!enable_n && $stable(rw)) [*4] ##1 enable_n)
    else $error("shared strobe length or direction unstable");
  AST_SEL_HOLD: assert property (!shared_mode && !(rd_n && wr_n) && !$past(rd_n && wr_n) |-> $stable(sel))
    else $error("register select moved during a strobe");

  // =====================================================================
  // Coverage of the main transfer kinds
  cover property ($rose(rd_strobe));
  cover property ($fell(wr_n));
  cover property (shared_mode && $fell(enable_n));
endmodule
